// ---- rtl/pss_ip_next.sv ----
/*
  combinational next value of the instruction pointer for plain advance.
  assumes the caller registers the result.
*/
`timescale 1ns/10ps
module pss_ip_next
(
  // current pointer and controls
  input  wire logic [13:0] i_ip,
  input  wire logic        i_len_two,
  input  wire logic        i_page_adv,
  // result
  output logic      [13:0] o_ip
);

  logic [7:0] low_step;
  logic [7:0] low_sum;
  logic [5:0] hi_next;

  always_comb
  begin
    low_step = i_len_two ? pss_pkg::TWO_8 : pss_pkg::ONE_8;
    low_sum  = i_ip[7:0] + low_step;
    hi_next  = i_page_adv ? (i_ip[13:8] + pss_pkg::ONE_6) : i_ip[13:8];
    o_ip     = {hi_next, low_sum};
  end

endmodule : pss_ip_next

// ---- rtl/pss_pkg.sv ----
/*
  shared types and constants for the program sequencer and call stack unit.
  assumes a single core clock domain and an external data ram port.
*/
package pss_pkg;

  localparam int unsigned IP_W         = 14;
  localparam int unsigned PAGE_W       = 8;
  localparam int unsigned HI_W         = 6;
  localparam int unsigned SP_W         = 8;
  localparam int unsigned DATA_W       = 8;

  localparam logic [13:0] IP_RST       = 14'h0000;
  localparam logic [7:0]  SP_RST       = 8'h00;
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [7:0]  IDX_RST      = 8'h00;
  localparam logic        IE_RST       = 1'b0;

  // second frame byte layout
  localparam int unsigned HI_POS       = 0;
  localparam int unsigned CARRY_POS    = 6;
  localparam int unsigned ZERO_POS     = 7;

  // one step of the pointer or length
  localparam logic [7:0]  ONE_8        = 8'h01;
  localparam logic [7:0]  TWO_8        = 8'h02;
  localparam logic [5:0]  ONE_6        = 6'h01;

  // operations presented by the decode stage
  typedef enum logic [3:0] {
    PSS_OP_SEQ      = 4'h0,
    PSS_OP_PAGE_ADV = 4'h1,
    PSS_OP_BRANCH   = 4'h2,
    PSS_OP_CALL     = 4'h3,
    PSS_OP_RET      = 4'h4,
    PSS_OP_INTERRUPT_EXIT_OP     = 4'h5,
    PSS_OP_SP_LOAD  = 4'h6,
    PSS_OP_INT_ACK  = 4'h7,
    PSS_OP_WR_ACC   = 4'h8,
    PSS_OP_WR_IDX   = 4'h9,
    PSS_OP_DI       = 4'hA,
    PSS_OP_EI       = 4'hB
  } pss_op_e;

  typedef struct packed {
    pss_op_e     op;
    logic        len_two;
    logic [13:0] target;
    logic [7:0]  data;
  } pss_cmd_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } pss_ram_s;

endpackage : pss_pkg

// ---- rtl/pss_sequencer.sv ----
/*
  program sequencer: instruction pointer, accumulator, index register,
  call stack pointer and frame push/pop through data ram.
  assumes decode presents one command per i_cmd_valid pulse while o_busy is low,
  and that ram read data is valid the cycle after a read request.
*/
// Notes on behaviour
// - instruction pointer is fourteen bits, covering sixteen kilobytes of program.
// - reset clears the instruction pointer to address zero.
// - sequential advance only changes the low eight pointer bits.
// - upper six bits advance only on the page advance operation.
// - pointer advances by one or two per instruction length.
// - interrupt acknowledge and call push next address plus carry and zero.
// - only interrupt exit restores both pointer and flags.
// - no firmware path to the pointer; frames sit in ram from zero.
// - reset clears the call stack pointer; stack grows upward.
// - stack pointer load copies the accumulator into the stack pointer.
// - interrupt acknowledge disables interrupts while saving the frame.
// - push writes byte one, increments, writes byte two, increments.
// - interrupt exit decrements, reads byte two, decrements, reads byte one.
// - interrupt exit re-enables interrupts on the same edge that restores pointer and flags.
// - call pushes pointer and flags and raises stack pointer by two.
// - subroutine exit restores pointer only, flags kept, pointer lowered two.
// - eight bit index register, auxiliary accumulator and index source.
// - eight bit accumulator holds general results.
// - targets crossing the four kilobyte boundary need not be supported.
`timescale 1ns/10ps
module pss_sequencer
(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_resetn,
  // command from decode
  input  wire logic              i_cmd_valid,
  input  wire pss_pkg::pss_cmd_s i_cmd,
  input  wire logic              i_carry,
  input  wire logic              i_zero,
  // data ram
  input  wire logic [7:0]        i_ram_rdata,
  output pss_pkg::pss_ram_s      o_ram,
  // state out
  output logic [13:0]            o_ip,
  output logic [7:0]             o_acc,
  output logic [7:0]             o_idx,
  output logic [7:0]             o_sp,
  output logic                   o_int_en,
  output logic                   o_flags_load,
  output logic                   o_carry,
  output logic                   o_zero,
  output logic                   o_busy
);

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_PUSH1 = 7'b0000010,
    ST_PUSH2 = 7'b0000100,
    ST_POP2R = 7'b0001000,
    ST_POP2D = 7'b0010000,
    ST_POP1R = 7'b0100000,
    ST_POP1D = 7'b1000000
  } pss_st_e;

  pss_st_e           st_ff;
  pss_st_e           nxt_st;
  logic [13:0]       ip_ff;
  logic [13:0]       ret_ip_ff;
  logic [1:0]        ret_flags_ff;
  logic              is_interrupt_exit_op_ff;
  logic [7:0]        hi_byte_ff;
  logic [7:0]        acc_ff;
  logic [7:0]        idx_ff;
  logic [7:0]        sp_ff;
  logic              ie_ff;
  logic              fl_ld_ff;
  logic              carry_ff;
  logic              zero_ff;
  pss_pkg::pss_ram_s ram_ff;
  logic [13:0]       seq_ip;
  logic              take;
  logic              take_push;
  logic              take_pop;
  logic              take_call;
  logic              take_ack;
  logic              take_interrupt_exit_op;
  logic              take_sp_load;
  logic              take_wr_acc;
  logic              take_wr_idx;
  logic              take_di;
  logic              take_ei;
  logic [7:0]        push_lo;
  logic [7:0]        push_hi;
  logic              pop_done;
  logic              restore_all;
  logic              busy_ff;

  function automatic logic [7:0] sp_step(input logic [7:0] sp, input logic up);
    sp_step = up ? sp + pss_pkg::ONE_8 : sp - pss_pkg::ONE_8;
  endfunction : sp_step

  // frame commands move two bytes through ram
  function automatic logic is_push_op(input pss_pkg::pss_op_e op);
    is_push_op = (op == pss_pkg::PSS_OP_CALL) || (op == pss_pkg::PSS_OP_INT_ACK);
  endfunction : is_push_op

  function automatic logic is_pop_op(input pss_pkg::pss_op_e op);
    is_pop_op = (op == pss_pkg::PSS_OP_RET) || (op == pss_pkg::PSS_OP_INTERRUPT_EXIT_OP);
  endfunction : is_pop_op

  assign take = i_cmd_valid && (st_ff == ST_IDLE);

  // one strobe per command, high only in the cycle it is taken
  assign take_push    = take && is_push_op(i_cmd.op);
  assign take_pop     = take && is_pop_op(i_cmd.op);
  assign take_call    = take && (i_cmd.op == pss_pkg::PSS_OP_CALL);
  assign take_ack     = take && (i_cmd.op == pss_pkg::PSS_OP_INT_ACK);
  assign take_interrupt_exit_op    = take && (i_cmd.op == pss_pkg::PSS_OP_INTERRUPT_EXIT_OP);
  assign take_sp_load = take && (i_cmd.op == pss_pkg::PSS_OP_SP_LOAD);
  assign take_wr_acc  = take && (i_cmd.op == pss_pkg::PSS_OP_WR_ACC);
  assign take_wr_idx  = take && (i_cmd.op == pss_pkg::PSS_OP_WR_IDX);
  assign take_di      = take && (i_cmd.op == pss_pkg::PSS_OP_DI);
  assign take_ei      = take && (i_cmd.op == pss_pkg::PSS_OP_EI);

  // frame bytes: pointer low first, high bits under the flags second
  assign push_lo     = take_call ? seq_ip[7:0] : ip_ff[7:0];
  assign push_hi     = {ret_flags_ff, ret_ip_ff[13:8]};
  assign pop_done    = (st_ff == ST_POP1D);
  assign restore_all = pop_done && is_interrupt_exit_op_ff;

  pss_ip_next i_pss_ip_next
  (
    .i_ip       (ip_ff),
    .i_len_two  (i_cmd.len_two),
    .i_page_adv (i_cmd.op == pss_pkg::PSS_OP_PAGE_ADV),
    .o_ip       (seq_ip)
  );

  // frame state machine
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE:
      begin
        if (take_push)
          nxt_st = ST_PUSH1;
        else if (take_pop)
          nxt_st = ST_POP2R;
      end
      ST_PUSH1: nxt_st = ST_PUSH2;
      ST_PUSH2: nxt_st = ST_IDLE;
      ST_POP2R: nxt_st = ST_POP2D;
      ST_POP2D: nxt_st = ST_POP1R;
      ST_POP1R: nxt_st = ST_POP1D;
      ST_POP1D: nxt_st = ST_IDLE;
      default:  nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      st_ff <= ST_IDLE;
    else
      st_ff <= nxt_st;
  end

  // return frame capture
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ret_ip_ff    <= pss_pkg::IP_RST;
      ret_flags_ff <= 2'h0;
      is_interrupt_exit_op_ff   <= 1'b0;
    end
    else if (take)
    begin
      // call returns past itself; acknowledge returns to the pending fetch
      ret_ip_ff    <= (i_cmd.op == pss_pkg::PSS_OP_CALL) ? seq_ip : ip_ff;
      ret_flags_ff <= {i_zero, i_carry};
      is_interrupt_exit_op_ff   <= take_interrupt_exit_op;
    end
  end

  // instruction pointer
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ip_ff <= pss_pkg::IP_RST;
    else if (st_ff == ST_POP1D)
      ip_ff <= {hi_byte_ff[pss_pkg::HI_POS +: 6], i_ram_rdata};
    else if (take)
    begin
      unique case (i_cmd.op)
        pss_pkg::PSS_OP_BRANCH,
        pss_pkg::PSS_OP_CALL:    ip_ff <= i_cmd.target;
        pss_pkg::PSS_OP_INT_ACK,
        pss_pkg::PSS_OP_RET,
        pss_pkg::PSS_OP_INTERRUPT_EXIT_OP:    ip_ff <= ip_ff;
        default:                 ip_ff <= seq_ip;
      endcase
    end
  end

  // second byte held until the first arrives
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      hi_byte_ff <= 8'h00;
    else if (st_ff == ST_POP2D)
      hi_byte_ff <= i_ram_rdata;
  end

  // accumulator, loaded with write-back results
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      acc_ff <= pss_pkg::ACC_RST;
    else if (take_wr_acc)
      acc_ff <= i_cmd.data;
  end

  // index register, auxiliary accumulator and index source
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      idx_ff <= pss_pkg::IDX_RST;
    else if (take_wr_idx)
      idx_ff <= i_cmd.data;
  end

  // call stack pointer
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      sp_ff <= pss_pkg::SP_RST;
    else if (take_sp_load)
      sp_ff <= acc_ff;
    else if (st_ff == ST_PUSH1 || st_ff == ST_PUSH2)
      sp_ff <= sp_step(sp_ff, 1'b1);
    else if (take_pop)
      sp_ff <= sp_step(sp_ff, 1'b0);
    else if (st_ff == ST_POP2D)
      sp_ff <= sp_step(sp_ff, 1'b0);
  end

  // ram port, registered; address follows the pointer at each step
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ram_ff <= '0;
    else
    begin
      ram_ff.wr <= (nxt_st == ST_PUSH1) || (nxt_st == ST_PUSH2);
      ram_ff.rd <= (nxt_st == ST_POP2R) || (nxt_st == ST_POP1R);
      unique case (nxt_st)
        ST_PUSH1:
        begin
          ram_ff.addr  <= sp_ff;
          ram_ff.wdata <= push_lo;
        end
        ST_PUSH2:
        begin
          // pointer steps on this same edge, so write one above it
          ram_ff.addr  <= sp_step(sp_ff, 1'b1);
          ram_ff.wdata <= push_hi;
        end
        ST_POP2R,
        ST_POP1R:
        begin
          ram_ff.addr  <= sp_step(sp_ff, 1'b0);
          ram_ff.wdata <= 8'h00;
        end
        ST_IDLE,
        ST_POP2D,
        ST_POP1D:
        begin
          ram_ff.addr  <= sp_ff;
          ram_ff.wdata <= 8'h00;
        end
      endcase
    end
  end

  // interrupt enable
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ie_ff <= pss_pkg::IE_RST;
    else if (take_ack)
      ie_ff <= 1'b0;
    else if (restore_all)
      ie_ff <= 1'b1;
    else if (take_di)
      ie_ff <= 1'b0;
    else if (take_ei)
      ie_ff <= 1'b1;
  end

  // flag restore strobe, interrupt exit only
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      fl_ld_ff <= 1'b0;
    else
      fl_ld_ff <= restore_all;
  end

  // restored flags, held until the next interrupt exit
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      carry_ff <= 1'b0;
      zero_ff  <= 1'b0;
    end
    else if (restore_all)
    begin
      carry_ff <= hi_byte_ff[pss_pkg::CARRY_POS];
      zero_ff  <= hi_byte_ff[pss_pkg::ZERO_POS];
    end
  end

  // busy while a frame moves
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      busy_ff <= 1'b0;
    else
      busy_ff <= (nxt_st != ST_IDLE);
  end

  // pointer leaves only as a fetch address, never to firmware
  assign o_ip         = ip_ff;
  assign o_acc        = acc_ff;
  assign o_idx        = idx_ff;
  assign o_sp         = sp_ff;
  assign o_int_en     = ie_ff;
  assign o_flags_load = fl_ld_ff;
  assign o_carry      = carry_ff;
  assign o_zero       = zero_ff;
  assign o_busy       = busy_ff;
  assign o_ram        = ram_ff;

endmodule : pss_sequencer

// ---- verif/pss_monitor.sv ----
/*
  checker on the sequencer ports.
  assumes one clock and the async low reset.
*/
`timescale 1ns/10ps
module pss_monitor
(
  // clock and reset
  input wire logic              i_core_clk,
  input wire logic              i_resetn,
  // command in, state out
  input wire logic              i_cmd_valid,
  input wire pss_pkg::pss_cmd_s i_cmd,
  input wire pss_pkg::pss_ram_s o_ram,
  input wire logic [13:0]       o_ip,
  input wire logic [7:0]        o_acc,
  input wire logic [7:0]        o_sp,
  input wire logic              o_int_en,
  input wire logic              o_flags_load,
  input wire logic              o_busy
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  logic            take;
  pss_pkg::pss_op_e op;
  assign take = i_cmd_valid && !o_busy;
  assign op   = i_cmd.op;

  property p_rst;
    $rose(i_resetn) |-> o_ip == 14'h0000 && o_sp == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_seq;
    take && op == pss_pkg::PSS_OP_SEQ |=> o_ip[13:8] == $past(o_ip[13:8])
      && o_ip[7:0] == $past(o_ip[7:0]) + ($past(i_cmd.len_two) ? 8'h02 : 8'h01);
  endproperty
  a_seq: assert property (p_seq) else $error("advance");
  property p_page;
    take && op == pss_pkg::PSS_OP_PAGE_ADV |=> o_ip[13:8] == $past(o_ip[13:8]) + 6'h01;
  endproperty
  a_page: assert property (p_page) else $error("page");
  property p_ld;
    take && op == pss_pkg::PSS_OP_SP_LOAD |=> o_sp == $past(o_acc);
  endproperty
  a_ld: assert property (p_ld) else $error("sp load");
  property p_ack;
    take && op == pss_pkg::PSS_OP_INT_ACK |=> o_ram.wr && o_ram.addr == $past(o_sp)
      && o_ram.wdata == $past(o_ip[7:0]) && !o_int_en;
  endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_push;
    take && (op == pss_pkg::PSS_OP_CALL || op == pss_pkg::PSS_OP_INT_ACK) |=> o_ram.wr
      ##1 o_ram.wr && o_ram.addr == $past(o_ram.addr) + 8'h01 ##1 o_sp == $past(o_sp, 3) + 8'h02;
  endproperty
  a_push: assert property (p_push) else $error("push");
  property p_pop;
    take && (op == pss_pkg::PSS_OP_RET || op == pss_pkg::PSS_OP_INTERRUPT_EXIT_OP) |=> o_ram.rd
      && o_ram.addr == $past(o_sp) - 8'h01 ##2 o_ram.rd && o_ram.addr == $past(o_sp, 3) - 8'h02;
  endproperty
  a_pop: assert property (p_pop) else $error("pop");
  property p_interrupt_exit_op;
    take && op == pss_pkg::PSS_OP_INTERRUPT_EXIT_OP |-> ##5 o_int_en && o_flags_load && o_sp == $past(o_sp, 5) - 8'h02;
  endproperty
  a_interrupt_exit_op: assert property (p_interrupt_exit_op) else $error("interrupt_exit_op");
  property p_ret;
    take && op == pss_pkg::PSS_OP_RET |=> (!o_flags_load)[*6];
  endproperty
  a_ret: assert property (p_ret) else $error("ret flags");
endmodule : pss_monitor

bind pss_sequencer pss_monitor i_pss_monitor (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_ram(o_ram), .o_ip(o_ip), .o_acc(o_acc), .o_sp(o_sp),
  .o_int_en(o_int_en), .o_flags_load(o_flags_load), .o_busy(o_busy));

// ---- verif/tb_program_sequencer_stack_unit.sv ----
/*
  self-checking bench for the sequencer with a small data ram.
  assumes the checker binds itself.
*/
`timescale 1ns/10ps
module tb_program_sequencer_stack_unit;
  logic              i_core_clk  = 1'b0;
  logic              i_resetn    = 1'b0;
  logic              i_cmd_valid = 1'b0;
  pss_pkg::pss_cmd_s i_cmd       = '0;
  logic              i_carry     = 1'b0;
  logic              i_zero      = 1'b0;
  logic [7:0]        i_ram_rdata = 8'h00;
  pss_pkg::pss_ram_s o_ram;
  logic [13:0]       o_ip;
  logic [7:0]        o_acc, o_idx, o_sp;
  logic              o_int_en, o_flags_load, o_carry, o_zero, o_busy, fl_seen;
  logic [7:0]        mem [256];
  int                checks      = 0;
  int                miscompares = 0;

  always #20 i_core_clk = ~i_core_clk;

  pss_sequencer i_pss_sequencer (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .i_carry(i_carry), .i_zero(i_zero), .i_ram_rdata(i_ram_rdata), .o_ram(o_ram),
    .o_ip(o_ip), .o_acc(o_acc), .o_idx(o_idx), .o_sp(o_sp), .o_int_en(o_int_en),
    .o_flags_load(o_flags_load), .o_carry(o_carry), .o_zero(o_zero), .o_busy(o_busy));

  // ram answers one cycle after the read strobe
  always @(posedge i_core_clk)
  begin
    if (o_ram.wr)
      mem[o_ram.addr] <= o_ram.wdata;
    if (o_ram.rd)
      i_ram_rdata <= mem[o_ram.addr];
  end

  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic flags(input logic c, input logic z);
    @(posedge i_core_clk);
    i_carry <= c;
    i_zero  <= z;
  endtask : flags

  task automatic send(input pss_pkg::pss_op_e op, input logic len, input logic [13:0] tgt, input logic [7:0] d);
    int n = 0;
    fl_seen = 1'b0;
    @(posedge i_core_clk);
    i_cmd_valid <= 1'b1;
    i_cmd       <= '{op, len, tgt, d};
    @(posedge i_core_clk);
    i_cmd_valid <= 1'b0;
    #1;
    while (o_busy !== 1'b0 && n < 20)
    begin
      fl_seen |= o_flags_load;
      @(posedge i_core_clk);
      #1;
      n++;
    end
    fl_seen |= o_flags_load;
    if (n == 20)
      miscompares++;
  endtask : send

  task automatic t_reset;
    chk(o_ip, 16'h0000, "ip");
    chk(o_sp, 16'h0000, "sp");
  endtask : t_reset

  task automatic t_seq;
    send(pss_pkg::PSS_OP_SEQ, 1'b0, 14'h0000, 8'h00);
    chk(o_ip, 16'h0001, "one byte");
    send(pss_pkg::PSS_OP_SEQ, 1'b1, 14'h0000, 8'h00);
    chk(o_ip, 16'h0003, "two bytes");
    send(pss_pkg::PSS_OP_BRANCH, 1'b0, 14'h01FE, 8'h00);
    send(pss_pkg::PSS_OP_SEQ, 1'b1, 14'h0000, 8'h00);
    chk(o_ip, 16'h0100, "page wrap");
    send(pss_pkg::PSS_OP_PAGE_ADV, 1'b0, 14'h0000, 8'h00);
    chk(o_ip[13:8], 16'h0002, "page advance");
  endtask : t_seq

  task automatic t_ack_interrupt_exit_op;
    send(pss_pkg::PSS_OP_WR_ACC, 1'b0, 14'h0000, 8'hFF);
    send(pss_pkg::PSS_OP_WR_IDX, 1'b0, 14'h0000, 8'hA5);
    chk({o_acc, o_idx}, 16'hFFA5, "acc idx");
    send(pss_pkg::PSS_OP_SP_LOAD, 1'b0, 14'h0000, 8'h00);
    chk(o_sp, 16'h00FF, "sp load");
    send(pss_pkg::PSS_OP_EI, 1'b0, 14'h0000, 8'h00);
    send(pss_pkg::PSS_OP_BRANCH, 1'b0, 14'h2A55, 8'h00);
    flags(1'b0, 1'b1);
    send(pss_pkg::PSS_OP_INT_ACK, 1'b0, 14'h0000, 8'h00);
    chk(o_int_en, 16'h0000, "ack disables");
    chk({mem[8'hFF], mem[8'h00]}, 16'h55AA, "ack frame");
    chk(o_sp, 16'h0001, "sp wrap");
    send(pss_pkg::PSS_OP_BRANCH, 1'b0, 14'h0000, 8'h00);
    flags(1'b1, 1'b0);
    send(pss_pkg::PSS_OP_INTERRUPT_EXIT_OP, 1'b0, 14'h0000, 8'h00);
    chk(o_ip, 16'h2A55, "interrupt_exit_op ip");
    chk({o_carry, o_zero, o_int_en, fl_seen}, 16'h0007, "interrupt_exit_op flags");
    chk(o_sp, 16'h00FF, "interrupt_exit_op sp");
  endtask : t_ack_interrupt_exit_op

  task automatic t_call_ret;
    send(pss_pkg::PSS_OP_WR_ACC, 1'b0, 14'h0000, 8'h10);
    send(pss_pkg::PSS_OP_SP_LOAD, 1'b0, 14'h0000, 8'h00);
    send(pss_pkg::PSS_OP_BRANCH, 1'b0, 14'h1234, 8'h00);
    flags(1'b1, 1'b0);
    send(pss_pkg::PSS_OP_CALL, 1'b1, 14'h0456, 8'h00);
    chk(o_ip, 16'h0456, "call target");
    chk({mem[8'h10], mem[8'h11]}, 16'h3652, "call frame");
    chk(o_sp, 16'h0012, "call sp");
    send(pss_pkg::PSS_OP_RET, 1'b0, 14'h0000, 8'h00);
    chk(o_ip, 16'h1236, "ret ip");
    chk({o_carry, o_zero, fl_seen, o_sp}, 16'h0210, "ret flags sp");
    send(pss_pkg::PSS_OP_DI, 1'b0, 14'h0000, 8'h00);
    chk(o_int_en, 16'h0000, "di");
  endtask : t_call_ret

  task automatic t_mid_reset;
    @(posedge i_core_clk);
    i_resetn <= 1'b0;
    @(posedge i_core_clk);
    i_resetn <= 1'b1;
    #1;
    chk(o_ip, 16'h0000, "ip after reset");
    chk(o_sp, 16'h0000, "sp after reset");
  endtask : t_mid_reset

  initial
  begin
    repeat (3) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    #1;
    t_reset();
    t_seq();
    t_ack_interrupt_exit_op();
    t_call_ret();
    t_mid_reset();
    stop_test();
  end

  // watchdog at 1000 cycles, well past the expected run of under a hundred cycles
  initial
  begin
    #40000;
    miscompares++;
    stop_test();
  end
endmodule : tb_program_sequencer_stack_unit
